/* File: design/rvs_pkg.sv */
package rvs_pkg;
	// ==========================================
	// Geometry
	localparam int NUM_LINES = 64;
	localparam int LINE_W = 6;
	localparam int BASE_W = 7;
	localparam int VEC_W = 15;
	localparam int WORD_W = 28;
	localparam int FILE_DEPTH = 64;
	localparam int FILE_AW = 6;
	localparam int WORDS_PER_LINE = 4;
	// Lines below this number get automatic register saving
	localparam logic [5:0] SAVE_LINE_LIMIT = 6'h10;
	// Vector field positions
	localparam int VEC_BASE_LSB = 8;
	localparam int VEC_LINE_LSB = 2;
	localparam logic [1:0] VEC_LOW_BITS = 2'h0;
	// Saved word layout
	localparam int FAULT_MSB = 27;
	localparam int FAULT_LSB = 24;
	localparam int PAR_BIT = 27;
	localparam int ACC_MSB = 23;
	// ==========================================
	// Register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_BASE = 8'h04;
	localparam logic [7:0] ADDR_MASK_LO = 8'h08;
	localparam logic [7:0] ADDR_MASK_HI = 8'h0c;
	localparam logic [7:0] ADDR_RECORD_LO = 8'h10;
	localparam logic [7:0] ADDR_RECORD_HI = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_RESTORE = 8'h1c;
	localparam logic [7:0] ADDR_CRA = 8'h20;
	localparam logic [7:0] ADDR_FILE_IDX = 8'h24;
	localparam logic [7:0] ADDR_FILE_DATA = 8'h28;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_AUTO_DIS_BIT = 1;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	typedef enum logic [1:0] {
		RVS_IDLE,
		RVS_OFFER,
		RVS_SAVE
	} rvs_state_e;
endpackage

/* File: design/rvs_reg_file.sv */
`timescale 1ns/1ps
module rvs_reg_file (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Access
	rvs_save_if.mem port
);
	logic [rvs_pkg::WORD_W-1:0] mem_r [rvs_pkg::FILE_DEPTH];
	// ==========================================
	// Storage, flops indexed by word address
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < rvs_pkg::FILE_DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else if (port.wr_en) begin
			mem_r[port.wr_addr] <= port.wr_data;
		end
	end
	assign port.rd_data = mem_r[port.rd_addr];
endmodule

/* File: design/rvs_save_if.sv */
`timescale 1ns/1ps
interface rvs_save_if;
	logic wr_en;
	logic [5:0] wr_addr;
	logic [27:0] wr_data;
	logic [5:0] rd_addr;
	logic [27:0] rd_data;
	modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

/* File: design/rvs_unit.sv */
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - On recognition present a 15-bit vector address to the processor.
// - Vector base loaded by set-base write, held until next such write.
// - Vector is base in 14:8, line in 7:2, zeros in 1:0.
// - Lines 0 to 77 octal map straight into the six line bits.
// - A 64-word register file holds saved processor registers.
// - Only lines 0 to 17 octal save registers; others have none.
// - Saving line owns four words starting at four times its number.
// - Second word holds four fault flags in 27:24, then condition and index.
// - Word three bit 27 is its parity; word four bit 27 group parity.
// - Words three and four carry accumulator and extension in 23:0.
// - Save start word comes from the line recognised at interrupt time.
// - Lines record only when masked in; a recorded line ignores samples.
// - Recognise highest recorded line, block more, keep recording.
// - Raise interrupt signal; processor takes it without mask or enable.
// - For lines 0-17 octal write sent registers into the line's words.
// - Recognised line locked out until restore; higher lines still allowed.
// - Fixed priority: line 0 highest, last line lowest.
// - After line 20-77 octal interrupt, recognition waits for the condition-to-A op.
// - Recognise only while enabled; keep recording while disabled.
// - Restore re-activates the processed line and all lower-priority lines.
module rvs_unit (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// External interrupt lines
	input wire logic [63:0] irq_lines,
	// Processor vector handshake
	output logic rt_irq,
	output logic [14:0] vector_addr,
	output logic save_req,
	input wire logic cpu_ack,
	// Processor register stream
	input wire logic reg_valid,
	input wire logic [27:0] reg_data,
	output logic save_done
);
	rvs_save_if sif ();
	rvs_reg_file u_file (
		.clk(clk),
		.rst(rst),
		.port(sif)
	);

	rvs_pkg::rvs_state_e state_r;
	logic [63:0] sync1_r, sync2_r;
	logic [63:0] mask_r, record_r, lock_r;
	logic [rvs_pkg::BASE_W-1:0] base_r;
	logic enable_r, auto_dis_r, cra_block_r;
	logic [5:0] line_r;
	logic [1:0] word_cnt_r;
	logic [5:0] file_idx_r;

	// ==========================================
	// AHB-Lite slave: zero wait states, always OKAY
	logic ph_valid_r, ph_write_r;
	logic [7:0] ph_addr_r;
	logic wr_fire, rd_fire;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	always_ff @(posedge clk) begin
		if (rst) begin
			ph_valid_r <= 1'b0;
			ph_write_r <= 1'b0;
			ph_addr_r <= '0;
		end else if (hready) begin
			ph_valid_r <= hsel && htrans[1];
			ph_write_r <= hwrite;
			ph_addr_r <= haddr[7:0];
		end
	end
	assign wr_fire = ph_valid_r && ph_write_r;
	assign rd_fire = ph_valid_r && !ph_write_r;

	// ==========================================
	// Input synchroniser
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= irq_lines;
			sync2_r <= sync1_r;
		end
	end

	// ==========================================
	// Recognition
	logic recog_ok;
	logic [63:0] cand;
	logic found;
	logic [5:0] pick;
	logic restore_wr, cra_wr;
	logic [5:0] restore_line;
	assign restore_wr = wr_fire && ph_addr_r == rvs_pkg::ADDR_RESTORE;
	assign cra_wr = wr_fire && ph_addr_r == rvs_pkg::ADDR_CRA;
	assign restore_line = hwdata[5:0];
	assign recog_ok = enable_r && !cra_block_r && state_r == rvs_pkg::RVS_IDLE;
	// Only lines of higher priority than every lock may be recognised
	logic [63:0] allow;
	always_comb begin
		allow = '1;
		for (int i = 0; i < rvs_pkg::NUM_LINES; i++) begin
			if (lock_r[i]) begin
				for (int j = i; j < rvs_pkg::NUM_LINES; j++) begin
					allow[j] = 1'b0;
				end
			end
		end
	end
	assign cand = record_r & allow;
	always_comb begin
		found = 1'b0;
		pick = '0;
		for (int i = rvs_pkg::NUM_LINES - 1; i >= 0; i--) begin
			if (cand[i]) begin
				found = 1'b1;
				pick = 6'(i);
			end
		end
	end
	logic take;
	assign take = recog_ok && found;

	// ==========================================
	// Record and lock flags, one per line
	genvar g;
	generate
		for (g = 0; g < rvs_pkg::NUM_LINES; g++) begin : g_line
			logic unlock;
			assign unlock = restore_wr && 6'(g) >= restore_line;
			always_ff @(posedge clk) begin
				if (rst) begin
					record_r[g] <= 1'b0;
					lock_r[g] <= 1'b0;
				end else begin
					if (take && pick == 6'(g)) begin
						record_r[g] <= 1'b0;
						lock_r[g] <= 1'b1;
					end else begin
						if (unlock) begin
							lock_r[g] <= 1'b0;
						end
						// Recorded lines ignore later samples; locked lines are not recorded
						if (!record_r[g] && !lock_r[g] && mask_r[g] && sync2_r[g]) begin
							record_r[g] <= 1'b1;
						end
					end
				end
			end
		end
	endgenerate

	// ==========================================
	// Software registers
	always_ff @(posedge clk) begin
		if (rst) begin
			mask_r <= '0;
			base_r <= '0;
			auto_dis_r <= 1'b0;
			file_idx_r <= '0;
		end else if (wr_fire) begin
			unique case (ph_addr_r)
				rvs_pkg::ADDR_BASE: base_r <= hwdata[rvs_pkg::BASE_W-1:0];
				rvs_pkg::ADDR_MASK_LO: mask_r[31:0] <= hwdata;
				rvs_pkg::ADDR_MASK_HI: mask_r[63:32] <= hwdata;
				rvs_pkg::ADDR_CTRL: auto_dis_r <= hwdata[rvs_pkg::CTRL_AUTO_DIS_BIT];
				rvs_pkg::ADDR_FILE_IDX: file_idx_r <= hwdata[5:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			enable_r <= 1'b0;
		end else if (wr_fire && ph_addr_r == rvs_pkg::ADDR_CTRL) begin
			enable_r <= hwdata[rvs_pkg::CTRL_EN_BIT];
		end else if (take && auto_dis_r) begin
			enable_r <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			cra_block_r <= 1'b0;
		end else if (state_r == rvs_pkg::RVS_OFFER && cpu_ack
			&& line_r >= rvs_pkg::SAVE_LINE_LIMIT) begin
			cra_block_r <= 1'b1;
		end else if (cra_wr) begin
			cra_block_r <= 1'b0;
		end
	end

	// ==========================================
	// Offer and save sequence
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= rvs_pkg::RVS_IDLE;
			line_r <= '0;
			word_cnt_r <= '0;
		end else begin
			unique case (state_r)
				rvs_pkg::RVS_IDLE: begin
					if (take) begin
						line_r <= pick;
						state_r <= rvs_pkg::RVS_OFFER;
					end
				end
				rvs_pkg::RVS_OFFER: begin
					// Line held until ack; base_r is not latched, so a base write during the offer still changes the vector
					if (cpu_ack) begin
						word_cnt_r <= '0;
						state_r <= line_r < rvs_pkg::SAVE_LINE_LIMIT ?
							rvs_pkg::RVS_SAVE : rvs_pkg::RVS_IDLE;
					end
				end
				rvs_pkg::RVS_SAVE: begin
					if (reg_valid) begin
						word_cnt_r <= word_cnt_r + 2'h1;
						if (word_cnt_r == 2'h3) begin
							state_r <= rvs_pkg::RVS_IDLE;
						end
					end
				end
				default: state_r <= rvs_pkg::RVS_IDLE;
			endcase
		end
	end

	assign rt_irq = state_r == rvs_pkg::RVS_OFFER;
	assign vector_addr = {base_r, line_r, rvs_pkg::VEC_LOW_BITS};
	assign save_req = state_r == rvs_pkg::RVS_SAVE;
	assign save_done = state_r == rvs_pkg::RVS_SAVE && reg_valid && word_cnt_r == 2'h3;

	// Words arrive already laid out and with parity from the processor
	assign sif.wr_en = state_r == rvs_pkg::RVS_SAVE && reg_valid;
	assign sif.wr_addr = {line_r[3:0], word_cnt_r};
	assign sif.wr_data = reg_data;
	assign sif.rd_addr = file_idx_r;

	// ==========================================
	// Read data
	always_ff @(posedge clk) begin
		if (rst) begin
			hrdata <= rvs_pkg::RESET_WORD;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			unique case (haddr[7:0])
				rvs_pkg::ADDR_CTRL: hrdata <= {30'h0, auto_dis_r, enable_r};
				rvs_pkg::ADDR_BASE: hrdata <= {25'h0, base_r};
				rvs_pkg::ADDR_MASK_LO: hrdata <= mask_r[31:0];
				rvs_pkg::ADDR_MASK_HI: hrdata <= mask_r[63:32];
				rvs_pkg::ADDR_RECORD_LO: hrdata <= record_r[31:0];
				rvs_pkg::ADDR_RECORD_HI: hrdata <= record_r[63:32];
				rvs_pkg::ADDR_STATUS: hrdata <= {22'h0, cra_block_r, state_r, line_r, 1'b0};
				rvs_pkg::ADDR_FILE_DATA: hrdata <= {4'h0, sif.rd_data};
				default: hrdata <= rvs_pkg::RESET_WORD;
			endcase
		end
	end

	// ==========================================
	// Checks
	property p_vec_hold;
		@(posedge clk) disable iff (rst)
		rt_irq && !cpu_ack |=> rt_irq && $stable(vector_addr);
	endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vector changed before ack");
	property p_vec_low;
		@(posedge clk) disable iff (rst)
		rt_irq |-> vector_addr[1:0] == rvs_pkg::VEC_LOW_BITS && vector_addr[14:8] == base_r
			&& lock_r[vector_addr[7:2]];
	endproperty
	a_vec_low: assert property (p_vec_low) else $error("vector format wrong");
	property p_no_save_high;
		@(posedge clk) disable iff (rst)
		rt_irq && cpu_ack && vector_addr[7:6] != 2'h0 |=> !save_req;
	endproperty
	a_no_save_high: assert property (p_no_save_high) else $error("save for high line");
	property p_save_low;
		@(posedge clk) disable iff (rst)
		rt_irq && cpu_ack && vector_addr[7:6] == 2'h0 |=> save_req;
	endproperty
	a_save_low: assert property (p_save_low) else $error("missing save");
	property p_wr_addr;
		@(posedge clk) disable iff (rst)
		sif.wr_en |-> sif.wr_addr[5:2] == line_r[3:0];
	endproperty
	a_wr_addr: assert property (p_wr_addr) else $error("save word out of line area");
	property p_disabled;
		@(posedge clk) disable iff (rst)
		!enable_r && !rt_irq |=> !rt_irq;
	endproperty
	a_disabled: assert property (p_disabled) else $error("recognised while disabled");
	property p_cra;
		@(posedge clk) disable iff (rst)
		cra_block_r && !cra_wr |=> !rt_irq;
	endproperty
	a_cra: assert property (p_cra) else $error("recognised before condition-to-A");
	property p_lock;
		@(posedge clk) disable iff (rst)
		$rose(rt_irq) |-> lock_r[line_r] && !record_r[line_r];
	endproperty
	a_lock: assert property (p_lock) else $error("recognised line not locked");
	property p_prio;
		@(posedge clk) disable iff (rst)
		take |-> (cand & ((64'h1 << pick) - 64'h1)) == 64'h0;
	endproperty
	a_prio: assert property (p_prio) else $error("lower priority picked");
endmodule

/* File: tb/rvs_cpu_model.sv */
`timescale 1ns/1ps
module rvs_cpu_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Vector handshake
	input wire logic rt_irq,
	input wire logic [14:0] vector_addr,
	input wire logic save_req,
	output logic cpu_ack,
	// Register stream
	output logic reg_valid,
	output logic [27:0] reg_data,
	// Pacing set by the bench
	input wire logic [3:0] dly
);
	logic [14:0] vec_q = 15'h0;
	logic [14:0] p_q = 15'h0;
	logic [11:0] cond_q = 12'h0;
	// ==========================================
	// Accept a vector, then stream registers for saving lines
	initial begin
		cpu_ack = 1'b0;
		reg_valid = 1'b0;
		reg_data = 28'h0;
		forever begin
			@(posedge clk);
			if (!rst && rt_irq === 1'b1) begin
				repeat (dly) @(posedge clk);
				vec_q = vector_addr;
				cpu_ack <= 1'b1;
				@(posedge clk);
				cpu_ack <= 1'b0;
				@(posedge clk);
				if (save_req === 1'b1) begin
					for (int k = 0; k < 4; k++) begin
						reg_valid <= 1'b1;
						reg_data <= rvs_tb_pkg::word_of(vec_q, k);
						@(posedge clk);
						if (dly != 4'h0 || k == 3) begin
							reg_valid <= 1'b0;
							// Released data toggles so a stale word never looks fresh
							reg_data <= ~rvs_tb_pkg::word_of(vec_q, k);
							repeat (dly) @(posedge clk);
						end
					end
					cond_q = 12'h0;
				end
				p_q = vec_q + 15'h1;
			end
		end
	end
endmodule

/* File: tb/rvs_tb_pkg.sv */
package rvs_tb_pkg;
	// ==========================================
	// Register words the processor streams for one vector
	function automatic logic [27:0] word_of(input logic [14:0] v, input int k);
		logic [27:0] w [4];
		w[0] = {13'h0, v};
		w[1] = {4'ha, 9'h0, v};
		w[2] = {4'h3, 24'h00a5a5 ^ {9'h0, v}};
		w[3] = {4'h6, 24'h5a0000 | {9'h0, v}};
		w[2][27] = ^w[2][26:0];
		w[3][27] = ^{w[0], w[1], w[2], w[3][26:0]};
		return w[k];
	endfunction
endpackage

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [63:0] irq_lines = 64'h0;
	logic [3:0] dly = 4'h0;
	logic [6:0] base_q = 7'h0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, rt_irq, save_req, cpu_ack, reg_valid, save_done;
	logic [14:0] vector_addr;
	logic [27:0] reg_data;
	int err_total = 0;
	int compares = 0;
	int save_cnt = 0;
	always #12.5 clk = ~clk;
	always @(posedge clk) if (save_done === 1'b1) save_cnt <= save_cnt + 1;
	rvs_unit rvs_unit_inst (.clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq_lines(irq_lines), .rt_irq(rt_irq),
		.vector_addr(vector_addr), .save_req(save_req), .cpu_ack(cpu_ack),
		.reg_valid(reg_valid), .reg_data(reg_data), .save_done(save_done));
	rvs_cpu_model rvs_cpu_model_inst (.clk(clk), .rst(rst), .rt_irq(rt_irq),
		.vector_addr(vector_addr), .save_req(save_req), .cpu_ack(cpu_ack),
		.reg_valid(reg_valid), .reg_data(reg_data), .dly(dly));
	// ==========================================
	// Shared tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask
	task automatic pulse(input logic [63:0] m);
		irq_lines <= m;
		repeat (4) @(posedge clk);
		irq_lines <= 64'h0;
	endtask
	task automatic quiet();
		int seen;
		seen = 0;
		repeat (30) begin
			@(posedge clk);
			if (rt_irq !== 1'b0) seen++;
		end
		chk("no interrupt", 32'h0, 32'(seen));
	endtask
	task automatic setup(input logic [6:0] b);
		base_q = b;
		wr(rvs_pkg::ADDR_BASE, {25'h0, b});
		wr(rvs_pkg::ADDR_MASK_LO, 32'hffff_ffff);
		wr(rvs_pkg::ADDR_MASK_HI, 32'hffff_ffff);
		wr(rvs_pkg::ADDR_CTRL, 32'h1);
		rchk("base", rvs_pkg::ADDR_BASE, {25'h0, b});
	endtask
	// Waits for the offer, checks the vector while it stands, then the saved words
	task automatic expect_vec(input logic [5:0] ln, input bit sv);
		int n;
		int s0;
		logic [14:0] ev;
		n = 0;
		s0 = save_cnt;
		ev = {base_q, ln, 2'h0};
		while (rt_irq !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk("rt_irq", 32'h1, {31'h0, rt_irq});
		while ((rt_irq === 1'b1 || save_req === 1'b1) && n < 200) begin
			if (rt_irq === 1'b1) chk("vector", {17'h0, ev}, {17'h0, vector_addr});
			@(posedge clk);
			n++;
		end
		chk("saves", 32'(sv), 32'(save_cnt - s0));
		for (int k = 0; k < 4 && sv; k++) begin
			wr(rvs_pkg::ADDR_FILE_IDX, 32'(4 * ln + k));
			rchk("file word", rvs_pkg::ADDR_FILE_DATA, {4'h0, rvs_tb_pkg::word_of(ev, k)});
		end
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		logic [7:0] regs [5];
		regs = '{rvs_pkg::ADDR_CTRL, rvs_pkg::ADDR_BASE, rvs_pkg::ADDR_MASK_LO,
			rvs_pkg::ADDR_RECORD_LO, rvs_pkg::ADDR_STATUS};
		foreach (regs[i]) rchk("reset value", regs[i], 32'h0);
		wr(8'h3c, 32'hffff_ffff);
		rchk("unmapped", 8'h3c, 32'h0);
		$display("Test reset done");
	endtask
	task automatic t_save();
		setup(7'h2b);
		dly <= 4'h3;
		pulse(64'h8000);
		expect_vec(6'hf, 1'b1);
		wr(rvs_pkg::ADDR_RESTORE, 32'hf);
		$display("Test save done");
	endtask
	task automatic t_high(input logic [5:0] ln, input logic [6:0] b);
		setup(b);
		dly <= 4'h0;
		pulse(64'h1 << ln);
		expect_vec(ln, 1'b0);
		pulse(64'h1);
		quiet();
		wr(rvs_pkg::ADDR_CRA, 32'h0);
		expect_vec(6'h0, 1'b1);
		wr(rvs_pkg::ADDR_RESTORE, 32'h0);
		$display("Test high line done");
	endtask
	task automatic t_prio();
		setup(7'h11);
		dly <= 4'h1;
		wr(rvs_pkg::ADDR_CTRL, 32'h0);
		wr(rvs_pkg::ADDR_MASK_LO, 32'hffff_ffef);
		pulse(64'h218);
		rchk("recorded", rvs_pkg::ADDR_RECORD_LO, 32'h208);
		quiet();
		// Enable with auto-disable, so recognition of line 3 must drop the enable
		wr(rvs_pkg::ADDR_CTRL, 32'h3);
		expect_vec(6'h3, 1'b1);
		rchk("auto disable", rvs_pkg::ADDR_CTRL, 32'h2);
		wr(rvs_pkg::ADDR_CTRL, 32'h1);
		quiet();
		wr(rvs_pkg::ADDR_RESTORE, 32'h3);
		expect_vec(6'h9, 1'b1);
		wr(rvs_pkg::ADDR_RESTORE, 32'h9);
		$display("Test priority done");
	endtask
	// ==========================================
	// Run control
	task automatic give_verdict();
		$display("Compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_save();
		t_high(6'h10, 7'h55);
		t_high(6'h3f, 7'h7f);
		t_prio();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		give_verdict();
	end
endmodule
